// ===== verilog/stack_addr_gen.sv
`timescale 1ns/10ps
module stack_addr_gen (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Decoder requests
    input wire agen_pkg::addr_req_s areq,
    input wire agen_pkg::stack_req_s sreq,
    input wire logic frame_pointer_active,
    output logic ready,
    // Datapath register write port
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [15:0] wr_data,
    // Operand answer
    output agen_pkg::ea_out_s ea,
    output logic [15:0] stack_pointer_register,
    // Stack memory port
    output logic st_wr,
    output logic st_rd,
    output logic [15:0] st_addr,
    output logic [15:0] st_wdata,
    input wire logic [15:0] st_rdata,
    // Return answer
    output logic ret_valid,
    output logic [22:0] ret_pc,
    output logic [7:0] ret_status
);
    typedef enum logic [2:0] {
        IDLE, PUSH_LO, PUSH_HI, POP_HI, POP_LO, POP_DONE
    } st_e;

    st_e state;
    logic [15:0] regs [16];
    logic [15:0] next_regs [16];
    logic take_addr;
    logic take_stack;
    logic sp_inc;
    logic sp_dec;
    logic modifies;
    logic [15:0] ptr_val;
    logic [15:0] base_val;
    logic [15:0] mod_val;

    function automatic logic is_mod(agen_pkg::addr_mode_e m);
        is_mod = (m == agen_pkg::M_POST_MOD) || (m == agen_pkg::M_PRE_MOD);
    endfunction : is_mod

    // Effective address for each addressing form.
    function automatic logic [15:0] ea_of(agen_pkg::addr_req_s r,
                                          logic [15:0] p,
                                          logic [15:0] b);
        case (r.mode)
            agen_pkg::M_FILE: begin
                if (r.move_any) begin
                    ea_of = r.file_addr;
                end else begin
                    ea_of =
                        16'(r.file_addr[agen_pkg::FILE_W-1:0]);
                end
            end
            agen_pkg::M_PRE_MOD: ea_of = p + r.offset;
            agen_pkg::M_INDEXED: ea_of = p + b;
            agen_pkg::M_LIT_OFFSET: ea_of = p + r.offset;
            default: ea_of = p;
        endcase
    endfunction : ea_of

    function automatic logic [15:0] lit_of(agen_pkg::addr_req_s r);
        if (r.lit10) begin
            lit_of = 16'(r.literal);
        end else begin
            lit_of = 16'(r.literal[agen_pkg::LIT5_W-1:0]);
        end
    endfunction : lit_of

    assign ready = (state == IDLE);
    assign take_stack = ready && sreq.valid && sreq.op != agen_pkg::S_NONE;
    // A stack request wins a shared cycle so the pointer has one mover.
    assign take_addr = ready && areq.valid && !sreq.valid;
    assign modifies = take_addr && is_mod(areq.mode);
    assign ptr_val = regs[areq.ptr];
    assign base_val = regs[areq.base];
    assign mod_val = ptr_val + areq.offset;
    assign st_wr = (state == PUSH_LO) || (state == PUSH_HI);
    assign st_rd = (state == POP_HI) || (state == POP_LO);
    assign sp_inc = st_wr;
    assign sp_dec = (take_stack && sreq.op == agen_pkg::S_RETURN)
                    || (state == POP_HI);
    assign st_addr = regs[agen_pkg::SP_IDX];
    assign stack_pointer_register = regs[agen_pkg::SP_IDX];

    always_comb begin
        next_regs = regs;
        if (wr_en) begin
            next_regs[wr_idx] = wr_data;
        end
        if (modifies) begin
            next_regs[areq.ptr] = mod_val;
        end
        if (sp_inc) begin
            next_regs[agen_pkg::SP_IDX] =
                regs[agen_pkg::SP_IDX] + agen_pkg::STACK_STEP;
        end else if (sp_dec) begin
            next_regs[agen_pkg::SP_IDX] =
                regs[agen_pkg::SP_IDX] - agen_pkg::STACK_STEP;
        end
        next_regs[agen_pkg::SP_IDX][0] = 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= '0;
            end
            regs[agen_pkg::SP_IDX] <= agen_pkg::SP_RESET;
        end else begin
            regs <= next_regs;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= IDLE;
            st_wdata <= '0;
        end else begin
            case (state)
                IDLE: begin
                    if (take_stack && sreq.op == agen_pkg::S_RETURN) begin
                        state <= POP_HI;
                    end else if (take_stack) begin
                        st_wdata <= sreq.pc[agen_pkg::PC_LO_W-1:0];
                        state <= PUSH_LO;
                    end
                end
                PUSH_LO: begin
                    // The request must still stand here: the upper word is
                    // built from it one cycle after it was taken.
                    st_wdata <= '0;
                    st_wdata[agen_pkg::PC_HI_W-1:0] <=
                        sreq.pc[agen_pkg::PC_LO_W+:agen_pkg::PC_HI_W];
                    if (sreq.op == agen_pkg::S_EXCEPT) begin
                        st_wdata[15:agen_pkg::BYTE_W] <=
                            sreq.status[agen_pkg::BYTE_W-1:0];
                    end
                    state <= PUSH_HI;
                end
                PUSH_HI: state <= IDLE;
                POP_HI: state <= POP_LO;
                POP_LO: state <= POP_DONE;
                POP_DONE: state <= IDLE;
                default: state <= IDLE;
            endcase
        end
    end

    // Sync stack RAM: read data arrives the cycle after the read strobe.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ret_valid <= 1'b0;
            ret_pc <= '0;
            ret_status <= '0;
        end else begin
            ret_valid <= (state == POP_DONE);
            if (state == POP_LO) begin
                ret_pc[agen_pkg::PC_LO_W+:agen_pkg::PC_HI_W] <=
                    st_rdata[agen_pkg::PC_HI_W-1:0];
                ret_status <= st_rdata[15:agen_pkg::BYTE_W];
            end
            if (state == POP_DONE) begin
                ret_pc[agen_pkg::PC_LO_W-1:0] <= st_rdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ea <= '0;
        end else begin
            ea.valid <= take_addr;
            ea.addr <= ea_of(areq, ptr_val, base_val);
            ea.mem <= areq.mode != agen_pkg::M_REG_DIRECT
                      && areq.mode != agen_pkg::M_LITERAL;
            ea.no_paging <= areq.ptr == agen_pkg::SP_IDX
                            || (areq.ptr == agen_pkg::FP_IDX
                                && frame_pointer_active);
            case (areq.mode)
                agen_pkg::M_REG_DIRECT: ea.value <= ptr_val;
                agen_pkg::M_FILE:
                    ea.value <= regs[agen_pkg::DEFAULT_WORKING_REGISTER_IDX];
                agen_pkg::M_LITERAL: ea.value <= lit_of(areq);
                default: ea.value <= base_val;
            endcase
        end
    end

    // Checks.
    logic [15:0] past_ptr;
    logic [15:0] past_base;
    logic quiet_ptr;
    assign quiet_ptr = !(wr_en && wr_idx == areq.ptr);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_push_lo(logic [15:0] lo);
        st_wr && st_wdata == lo;
    endsequence

    sequence s_push_hi(logic [6:0] hi, logic [7:0] up);
        st_wr && st_wdata[6:0] == hi && st_wdata[15:8] == up;
    endsequence

    property p_sp_bit0;
        stack_pointer_register[0] == 1'b0;
    endproperty
    a_sp_bit0: assert property (p_sp_bit0)
        else $error("stack pointer bit zero set");

    property p_sp_reset;
        $fell(sys_rst) |-> stack_pointer_register == agen_pkg::SP_RESET;
    endproperty
    a_sp_reset: assert property (p_sp_reset)
        else $error("stack pointer not reset value");

    property p_push_grow;
        st_wr |=> stack_pointer_register ==
            $past(st_addr) + agen_pkg::STACK_STEP;
    endproperty
    a_push_grow: assert property (p_push_grow)
        else $error("push did not advance pointer by two");

    property p_pop_shrink;
        sp_dec |=> stack_pointer_register ==
            $past(st_addr) - agen_pkg::STACK_STEP;
    endproperty
    a_pop_shrink: assert property (p_pop_shrink)
        else $error("pop did not lower pointer by two");

    property p_call_frame;
        take_stack && sreq.op == agen_pkg::S_CALL |=>
            s_push_lo($past(sreq.pc[15:0]))
            ##1 s_push_hi($past(sreq.pc[22:16], 2), 8'h00);
    endproperty
    a_call_frame: assert property (p_call_frame)
        else $error("call frame wrong");

    property p_exc_frame;
        take_stack && sreq.op == agen_pkg::S_EXCEPT |=> ##1
            s_push_hi($past(sreq.pc[22:16], 2), $past(sreq.status[7:0], 2));
    endproperty
    a_exc_frame: assert property (p_exc_frame)
        else $error("exception status byte not stacked");

    property p_file_near;
        take_addr && areq.mode == agen_pkg::M_FILE && !areq.move_any
            |=> ea.valid && ea.addr[15:13] == 3'h0;
    endproperty
    a_file_near: assert property (p_file_near)
        else $error("file address beyond near space");

    always_ff @(posedge mclk) begin
        past_ptr <= ptr_val;
        past_base <= base_val;
    end

    property p_post_mod;
        modifies && quiet_ptr && areq.mode == agen_pkg::M_POST_MOD
            && areq.ptr != agen_pkg::SP_IDX
            |=> ea.addr == past_ptr
                && regs[$past(areq.ptr)] == past_ptr + $past(areq.offset);
    endproperty
    a_post_mod: assert property (p_post_mod)
        else $error("post-modify address or update wrong");

    property p_pre_mod;
        modifies && areq.mode == agen_pkg::M_PRE_MOD
            |=> ea.addr == past_ptr + $past(areq.offset);
    endproperty
    a_pre_mod: assert property (p_pre_mod)
        else $error("pre-modify address wrong");

    property p_indexed;
        take_addr && areq.mode == agen_pkg::M_INDEXED
            |=> ea.addr == past_ptr + past_base;
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed address wrong");
endmodule : stack_addr_gen

// ===== verilog/agen_pkg.sv
package agen_pkg;
    localparam logic [15:0] SP_RESET = 16'h1000;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [3:0] DEFAULT_WORKING_REGISTER_IDX = 4'h0;
    localparam logic [3:0] FP_IDX = 4'hE;
    localparam logic [3:0] SP_IDX = 4'hF;
    localparam int FILE_W = 13;
    localparam int LIT5_W = 5;
    localparam int PC_LO_W = 16;
    localparam int PC_HI_W = 7;
    localparam int BYTE_W = 8;

    typedef enum logic [2:0] {
        M_FILE, M_REG_DIRECT, M_INDIRECT, M_POST_MOD,
        M_PRE_MOD, M_INDEXED, M_LIT_OFFSET, M_LITERAL
    } addr_mode_e;

    typedef enum logic [1:0] {
        S_NONE, S_CALL, S_EXCEPT, S_RETURN
    } stack_op_e;

    typedef struct packed {
        logic valid;
        addr_mode_e mode;
        logic move_any;
        logic [3:0] ptr;
        logic [3:0] base;
        logic [15:0] file_addr;
        logic [9:0] literal;
        logic lit10;
        logic [15:0] offset;
    } addr_req_s;

    typedef struct packed {
        logic valid;
        stack_op_e op;
        logic [22:0] pc;
        logic [15:0] status;
    } stack_req_s;

    typedef struct packed {
        logic valid;
        logic mem;
        logic no_paging;
        logic [15:0] addr;
        logic [15:0] value;
    } ea_out_s;
endpackage : agen_pkg

// ===== testbench/stack_mem_model.sv
`timescale 1ns/10ps
module stack_mem_model (
    // Clock
    input wire logic mclk,
    // Stack memory port
    input wire logic st_wr,
    input wire logic st_rd,
    input wire logic [15:0] st_addr,
    input wire logic [15:0] st_wdata,
    output logic [15:0] st_rdata
);
    logic [15:0] mem [0:32767];
    logic [15:0] rd_q;
    logic rd_vld;

    always_ff @(posedge mclk) begin
        if (st_wr) begin
            mem[st_addr[15:1]] <= st_wdata;
        end
        rd_vld <= st_rd;
        if (st_rd) begin
            rd_q <= mem[st_addr[15:1]];
        end
    end

    // Outside the read cycle the bus shows junk, never a stale word.
    assign st_rdata = rd_vld ? rd_q : ~rd_q;
endmodule : stack_mem_model

// ===== testbench/stack_addr_gen_tb.sv
`timescale 1ns/10ps
module stack_addr_gen_tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    agen_pkg::addr_req_s areq = '0;
    agen_pkg::stack_req_s sreq = '0;
    logic frame_pointer_active = 1'b0;
    logic ready;
    logic wr_en = 1'b0;
    logic [3:0] wr_idx = 4'h0;
    logic [15:0] wr_data = 16'h0000;
    agen_pkg::ea_out_s ea;
    logic [15:0] stack_pointer_register;
    logic st_wr;
    logic st_rd;
    logic [15:0] st_addr;
    logic [15:0] st_wdata;
    logic [15:0] st_rdata;
    logic ret_valid;
    logic [22:0] ret_pc;
    logic [7:0] ret_status;
    int n_fail = 0;
    int n_tests = 0;

    always #2 mclk = ~mclk;

    stack_addr_gen stack_addr_gen_i (.mclk(mclk), .sys_rst(sys_rst),
        .areq(areq), .sreq(sreq), .frame_pointer_active(frame_pointer_active),
        .ready(ready), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
        .ea(ea), .stack_pointer_register(stack_pointer_register),
        .st_wr(st_wr), .st_rd(st_rd), .st_addr(st_addr),
        .st_wdata(st_wdata), .st_rdata(st_rdata), .ret_valid(ret_valid),
        .ret_pc(ret_pc), .ret_status(ret_status));

    stack_mem_model stack_mem_model_i (.mclk(mclk), .st_wr(st_wr),
        .st_rd(st_rd), .st_addr(st_addr), .st_wdata(st_wdata),
        .st_rdata(st_rdata));

    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Polls for ready or for the return answer; a hang ends the run.
    task automatic wait_done(input bit want_ret);
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            #1;
            if (want_ret ? ret_valid === 1'b1 : ready === 1'b1) begin
                return;
            end
        end
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    endtask : wait_done

    task automatic wr_reg(input logic [3:0] idx, input logic [15:0] d);
        @(posedge mclk);
        #1;
        wr_en = 1'b1;
        wr_idx = idx;
        wr_data = d;
        @(posedge mclk);
        #1;
        wr_en = 1'b0;
    endtask : wr_reg

    // One field value serves as file address, offset and literal alike.
    task automatic addr_op(input agen_pkg::addr_mode_e m, input logic [3:0] p,
        input logic [3:0] b, input logic [15:0] v, input logic f);
        @(posedge mclk);
        #1;
        areq = '{valid: 1'b1, mode: m, move_any: f, ptr: p, base: b,
            file_addr: v, literal: v[9:0], lit10: f, offset: v};
        @(posedge mclk);
        #1;
        areq.valid = 1'b0;
        chk(ea.valid, 1'b1);
    endtask : addr_op

    task automatic stack_op(input agen_pkg::stack_op_e op,
        input logic [22:0] pc, input logic [15:0] st);
        @(posedge mclk);
        #1;
        sreq = '{valid: 1'b1, op: op, pc: pc, status: st};
        @(posedge mclk);
        #1;
        sreq.valid = 1'b0;
        wait_done(op == agen_pkg::S_RETURN);
        wait_done(1'b0);
    endtask : stack_op

    task automatic test_reset;
        chk(stack_pointer_register, 16'h1000);
        chk(st_addr, 16'h1000);
        chk(ready, 1'b1);
        chk(ea.valid, 1'b0);
        chk(ret_valid, 1'b0);
        chk(st_wr, 1'b0);
        chk(st_rd, 1'b0);
        $display("reset test done");
    endtask : test_reset

    // Reset again in mid-run, from a moved pointer, then push once more.
    task automatic test_rereset;
        @(posedge mclk);
        #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        chk(stack_pointer_register, 16'h1000);
        chk(ready, 1'b1);
        stack_op(agen_pkg::S_CALL, 23'h7F0001, 16'h0000);
        chk(stack_mem_model_i.mem[16'h1000 >> 1], 16'h0001);
        chk(stack_mem_model_i.mem[16'h1002 >> 1], 16'h007F);
        chk(stack_pointer_register, 16'h1004);
        $display("second reset test done");
    endtask : test_rereset

    task automatic test_push_pop;
        stack_op(agen_pkg::S_CALL, 23'h4A5B6C, 16'hFFFF);
        chk(stack_mem_model_i.mem[16'h1000 >> 1], 16'h5B6C);
        chk(stack_mem_model_i.mem[16'h1002 >> 1], 16'h004A);
        chk(stack_pointer_register, 16'h1004);
        stack_op(agen_pkg::S_EXCEPT, 23'h3CBEEF, 16'hA55A);
        chk(stack_mem_model_i.mem[16'h1004 >> 1], 16'hBEEF);
        chk(stack_mem_model_i.mem[16'h1006 >> 1], 16'h5A3C);
        chk(stack_pointer_register, 16'h1008);
        stack_op(agen_pkg::S_RETURN, 23'h000000, 16'h0000);
        chk(ret_pc, 23'h3CBEEF);
        chk(ret_status, 8'h5A);
        chk(stack_pointer_register, 16'h1004);
        stack_op(agen_pkg::S_RETURN, 23'h000000, 16'h0000);
        chk(ret_pc, 23'h4A5B6C);
        chk(ret_status, 8'h00);
        chk(stack_pointer_register, 16'h1000);
        $display("push pop test done");
    endtask : test_push_pop

    task automatic test_modes;
        wr_reg(4'h3, 16'h2000);
        wr_reg(4'h4, 16'h0010);
        wr_reg(4'h0, 16'h00AB);
        addr_op(agen_pkg::M_FILE, 4'h0, 4'h0, 16'hFFFF, 1'b0);
        chk(ea.addr, 16'h1FFF);
        chk(ea.value, 16'h00AB);
        addr_op(agen_pkg::M_FILE, 4'h0, 4'h0, 16'hFFFF, 1'b1);
        chk(ea.addr, 16'hFFFF);
        addr_op(agen_pkg::M_REG_DIRECT, 4'h3, 4'h0, 16'h0000, 1'b0);
        chk(ea.value, 16'h2000);
        chk(ea.mem, 1'b0);
        addr_op(agen_pkg::M_INDIRECT, 4'h3, 4'h4, 16'h0000, 1'b0);
        chk(ea.addr, 16'h2000);
        chk(ea.value, 16'h0010);
        chk(ea.no_paging, 1'b0);
        addr_op(agen_pkg::M_POST_MOD, 4'h3, 4'h0, 16'h0002, 1'b0);
        chk(ea.addr, 16'h2000);
        addr_op(agen_pkg::M_PRE_MOD, 4'h3, 4'h0, 16'hFFFC, 1'b0);
        chk(ea.addr, 16'h1FFE);
        addr_op(agen_pkg::M_INDEXED, 4'h3, 4'h4, 16'h0000, 1'b0);
        chk(ea.addr, 16'h200E);
        addr_op(agen_pkg::M_LIT_OFFSET, 4'h3, 4'h0, 16'h0100, 1'b0);
        chk(ea.addr, 16'h20FE);
        addr_op(agen_pkg::M_LITERAL, 4'h0, 4'h0, 16'h03FF, 1'b0);
        chk(ea.value, 16'h001F);
        addr_op(agen_pkg::M_LITERAL, 4'h0, 4'h0, 16'h03FF, 1'b1);
        chk(ea.value, 16'h03FF);
        $display("modes test done");
    endtask : test_modes

    task automatic test_pointers;
        wr_reg(4'hE, 16'h3000);
        frame_pointer_active = 1'b1;
        addr_op(agen_pkg::M_INDIRECT, 4'hE, 4'h0, 16'h0000, 1'b0);
        chk(ea.no_paging, 1'b1);
        frame_pointer_active = 1'b0;
        addr_op(agen_pkg::M_INDIRECT, 4'hE, 4'h0, 16'h0000, 1'b0);
        chk(ea.no_paging, 1'b0);
        wr_reg(4'hF, 16'h2001);
        chk(stack_pointer_register, 16'h2000);
        addr_op(agen_pkg::M_INDIRECT, 4'hF, 4'h0, 16'h0000, 1'b0);
        chk(ea.addr, 16'h2000);
        chk(ea.no_paging, 1'b1);
        stack_op(agen_pkg::S_CALL, 23'h000123, 16'h0000);
        chk(stack_mem_model_i.mem[16'h2000 >> 1], 16'h0123);
        chk(stack_pointer_register, 16'h2004);
        $display("pointer test done");
    endtask : test_pointers

    initial begin
        repeat (10) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        test_reset();
        test_push_pop();
        test_modes();
        test_pointers();
        test_rereset();
        end_sim();
    end
endmodule : stack_addr_gen_tb
